// ---- pkg/eepsl_defines.svh ----
// Constants of the serial EEPROM two-wire slave: codes, offsets, counts
`ifndef EEPSL_DEFINES_SVH
`define EEPSL_DEFINES_SVH

// ----------------------------------------------------------------
// Addressing
// ----------------------------------------------------------------
`define EEPSL_CTRL_CODE 4'hA
`define EEPSL_PROT_BASE 8'h80
`define EEPSL_PTR_RST 8'h00

// ----------------------------------------------------------------
// Bit slot counts within one nine-clock byte frame
// ----------------------------------------------------------------
`define EEPSL_CNT_RST 4'h0
`define EEPSL_CNT_FIRST 4'h1
`define EEPSL_RX_LAST 4'h7
`define EEPSL_ACK_SLOT 4'h8
`define EEPSL_MACK_SLOT 4'h9

// ----------------------------------------------------------------
// Write cycle timing
// ----------------------------------------------------------------
`define EEPSL_CLK_PERIOD_NS 25
`define EEPSL_TWR_NS 1000000
`define EEPSL_TWR_CYCLES (`EEPSL_TWR_NS / `EEPSL_CLK_PERIOD_NS)

`endif

// ---- pkg/eepsl_pkg.sv ----
// Types shared by the serial EEPROM two-wire slave
package eepsl_pkg;

  // ----------------------------------------------------------------
  // Link state, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    LK_IDLE  = 5'h01,
    LK_CTRL  = 5'h02,
    LK_ADDR  = 5'h04,
    LK_WDATA = 5'h08,
    LK_RDATA = 5'h10
  } eepsl_state_t;

  // ----------------------------------------------------------------
  // Control byte layout, first byte after a start
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] code;
    logic [2:0] cs;
    logic rnw;
  } eepsl_ctrl_t;

endpackage : eepsl_pkg

// ---- src/eepsl_slave.sv ----
// Serial EEPROM two-wire slave: bus conditions, addressing, byte/page write
`timescale 1ns/1ps
`include "eepsl_defines.svh"

module eepsl_slave #(
  parameter int WR_CYCLES = `EEPSL_TWR_CYCLES
) (
  // System clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Serial clock from the bus master
  input wire logic SCL_CLK,
  // Open-drain serial data
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  // Static straps and supply monitor
  input wire logic [2:0] CHIP_SELECT_PINS,
  input wire logic WP,
  input wire logic LOW_SUPPLY,
  // Status
  output logic BUSY
);
  import eepsl_pkg::*;

  localparam int CW = $clog2(WR_CYCLES + 1);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Protection hit for one word address
  function automatic logic is_prot(input logic wp, input logic [7:0] a);
    return wp && (a >= `EEPSL_PROT_BASE);
  endfunction : is_prot

  // Page-local pointer advance, upper nibble frozen
  function automatic logic [7:0] page_inc(input logic [7:0] a);
    return {a[7:4], a[3:0] + 4'h1};
  endfunction : page_inc

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] mem_q [256];
  logic [7:0] page_q [16];
  logic [15:0] valid_q;
  logic [7:0] ptr_q;
  logic arm_q;

  // ----------------------------------------------------------------
  // System domain: pin synchronisers
  // ----------------------------------------------------------------
  logic scl_s1_q, scl_s2_q, scl_d_q;
  logic sda_s1_q, sda_s2_q, sda_d_q;
  logic wp_s1_q, wp_s2_q;
  logic low_s1_q, low_s2_q;
  logic arm_s1_q, arm_s2_q;

  // Two flops on every foreign level; the third flops feed edge detection
  always_ff @(posedge CLOCK) begin
    scl_s1_q <= SCL_CLK;
    scl_s2_q <= scl_s1_q;
    scl_d_q <= scl_s2_q;
    sda_s1_q <= SDA_I;
    sda_s2_q <= sda_s1_q;
    sda_d_q <= sda_s2_q;
    wp_s1_q <= WP;
    wp_s2_q <= wp_s1_q;
    low_s1_q <= LOW_SUPPLY;
    low_s2_q <= low_s1_q;
    arm_s1_q <= arm_q;
    arm_s2_q <= arm_s1_q;
  end

  // ----------------------------------------------------------------
  // System domain: bus conditions
  // ----------------------------------------------------------------
  logic start_ev, stop_ev;
  logic start_tgl_q, bus_idle_q;

  // Data edge while clock stays high is a condition, never data
  assign start_ev = scl_s2_q && scl_d_q && sda_d_q && !sda_s2_q;
  assign stop_ev = scl_s2_q && scl_d_q && !sda_d_q && sda_s2_q;

  // Start is passed to the link as a toggle, safe across domains
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      start_tgl_q <= 1'b0;
    end else if (start_ev) begin
      start_tgl_q <= !start_tgl_q;
    end
  end

  // Idle flag forces the data driver off outside frames
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      bus_idle_q <= 1'b1;
    end else if (stop_ev) begin
      bus_idle_q <= 1'b1;
    end else if (start_ev) begin
      bus_idle_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // System domain: self-timed write cycle
  // ----------------------------------------------------------------
  logic launch, commit_en, used_q, busy_q;
  logic [CW-1:0] wcnt_q;
  logic [15:0] wr_en;

  // A stop after at least one acked data byte starts the cycle
  assign launch = stop_ev && arm_s2_q && !used_q && !busy_q;
  assign commit_en = launch && !low_s2_q;

  // One launch per armed frame; the link disarms at the next control byte
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      used_q <= 1'b0;
    end else if (launch) begin
      used_q <= 1'b1;
    end else if (!arm_s2_q) begin
      used_q <= 1'b0;
    end
  end

  // Busy spans the full time even when nothing is committed
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      busy_q <= 1'b0;
      wcnt_q <= '0;
    end else if (launch) begin
      busy_q <= 1'b1;
      wcnt_q <= CW'(WR_CYCLES - 1);
    end else if (busy_q) begin
      if (wcnt_q == '0) begin
        busy_q <= 1'b0;
      end else begin
        wcnt_q <= wcnt_q - CW'(1);
      end
    end
  end

  // Byte enables of the commit; protected words are silently dropped
  always_comb begin
    wr_en = '0;
    for (int i = 0; i < 16; i++) begin
      wr_en[i] = commit_en && valid_q[i]
        && !is_prot(wp_s2_q, {ptr_q[7:4], 4'(i)});
    end
  end

  // Page buffer is quiet here: the serial clock is parked high after a stop
  always_ff @(posedge CLOCK) begin
    for (int i = 0; i < 16; i++) begin
      if (wr_en[i]) begin
        mem_q[{ptr_q[7:4], 4'(i)}] <= page_q[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Link domain: synchronisers, first flop on fall, second on rise
  // ----------------------------------------------------------------
  logic stg1_q, stg2_q, busy1_q, busy2_q, lrst1_q, lrst2_q;
  logic [2:0] cs1_q, cs2_q;
  logic sda_p_q;

  always_ff @(negedge SCL_CLK) begin
    stg1_q <= start_tgl_q;
    busy1_q <= busy_q;
    lrst1_q <= RST;
    cs1_q <= CHIP_SELECT_PINS;
  end

  // Data is sampled on the rising serial clock edge, stable there by bus protocol
  always_ff @(posedge SCL_CLK) begin
    stg2_q <= stg1_q;
    busy2_q <= busy1_q;
    lrst2_q <= lrst1_q;
    cs2_q <= cs1_q;
    sda_p_q <= SDA_I;
  end

  // ----------------------------------------------------------------
  // Link domain: byte engine, acting on each falling edge
  // ----------------------------------------------------------------
  eepsl_state_t st_q, nxt_q, nxt_d;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, tx_q, rx_byte, rd_byte;
  logic seen_q, oe_q, ack_d;
  logic new_frame, rx_st, byte_done, rd_done, ctrl_ok;
  eepsl_ctrl_t cb;

  assign new_frame = stg2_q != seen_q;
  assign rx_st = (st_q == LK_CTRL) || (st_q == LK_ADDR) || (st_q == LK_WDATA);
  assign byte_done = !new_frame && rx_st && (cnt_q == `EEPSL_RX_LAST);
  assign rd_done = !new_frame && (st_q == LK_RDATA) && (cnt_q == `EEPSL_ACK_SLOT);
  assign rx_byte = {sh_q[6:0], sda_p_q};
  assign cb = rx_byte;
  // Memory is stable whenever a read is served, since busy refuses reads
  assign rd_byte = mem_q[ptr_q];
  assign ctrl_ok = (cb.code == `EEPSL_CTRL_CODE)
    && (cb.cs == cs2_q)
    && !busy2_q;

  // Acknowledge choice and next path for the byte just completed
  always_comb begin
    ack_d = 1'b1;
    nxt_d = LK_WDATA;
    if (st_q == LK_CTRL) begin
      ack_d = ctrl_ok;
      nxt_d = !ctrl_ok ? LK_IDLE : (cb.rnw ? LK_RDATA : LK_ADDR);
    end
  end

  // Shift register takes every sampled bit
  always_ff @(negedge SCL_CLK) begin
    sh_q <= rx_byte;
  end

  // Start toggle seen by the engine
  always_ff @(negedge SCL_CLK) begin
    seen_q <= stg2_q;
  end

  // Main engine: receive, acknowledge slot, transmit
  always_ff @(negedge SCL_CLK) begin
    if (lrst2_q) begin
      st_q <= LK_IDLE;
      nxt_q <= LK_IDLE;
      cnt_q <= `EEPSL_CNT_RST;
      oe_q <= 1'b0;
      tx_q <= 8'h00;
    end else if (new_frame) begin
      // First bit of the control byte was taken on the rising edge just gone
      st_q <= LK_CTRL;
      cnt_q <= `EEPSL_CNT_FIRST;
      oe_q <= 1'b0;
    end else begin
      unique case (st_q)
        LK_IDLE: begin
          oe_q <= 1'b0;
        end
        LK_CTRL, LK_ADDR, LK_WDATA: begin
          if (cnt_q == `EEPSL_RX_LAST) begin
            // Pull low across the whole ninth pulse
            oe_q <= ack_d;
            nxt_q <= nxt_d;
            cnt_q <= `EEPSL_ACK_SLOT;
          end else if (cnt_q == `EEPSL_ACK_SLOT) begin
            st_q <= nxt_q;
            if (nxt_q == LK_RDATA) begin
              oe_q <= !rd_byte[7];
              tx_q <= {rd_byte[6:0], 1'b0};
              cnt_q <= `EEPSL_CNT_FIRST;
            end else begin
              oe_q <= 1'b0;
              cnt_q <= `EEPSL_CNT_RST;
            end
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        LK_RDATA: begin
          if (cnt_q == `EEPSL_ACK_SLOT) begin
            // Release for the master's acknowledge
            oe_q <= 1'b0;
            cnt_q <= `EEPSL_MACK_SLOT;
          end else if (cnt_q == `EEPSL_MACK_SLOT) begin
            if (sda_p_q) begin
              st_q <= LK_IDLE;
              oe_q <= 1'b0;
            end else begin
              oe_q <= !rd_byte[7];
              tx_q <= {rd_byte[6:0], 1'b0};
              cnt_q <= `EEPSL_CNT_FIRST;
            end
          end else begin
            oe_q <= !tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
            cnt_q <= cnt_q + 4'h1;
          end
        end
        default: begin
          st_q <= LK_IDLE;
          oe_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Link domain: pointer and page buffer
  // ----------------------------------------------------------------
  // Page slots wrap, so a long burst keeps only the newest sixteen bytes
  always_ff @(negedge SCL_CLK) begin
    if (lrst2_q) begin
      ptr_q <= `EEPSL_PTR_RST;
      valid_q <= 16'h0000;
      arm_q <= 1'b0;
    end else if (byte_done && (st_q == LK_CTRL)) begin
      valid_q <= 16'h0000;
      arm_q <= 1'b0;
    end else if (byte_done && (st_q == LK_ADDR)) begin
      ptr_q <= rx_byte;
    end else if (byte_done && (st_q == LK_WDATA)) begin
      valid_q[ptr_q[3:0]] <= 1'b1;
      ptr_q <= page_inc(ptr_q);
      arm_q <= 1'b1;
    end else if (rd_done) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // Page data holds no control meaning, so it needs no reset
  always_ff @(negedge SCL_CLK) begin
    if (byte_done && (st_q == LK_WDATA)) begin
      page_q[ptr_q[3:0]] <= rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Idle gate also covers the link before its first clock edge
  assign SDA_OE = oe_q && !bus_idle_q;
  assign SDA_O = 1'b0;
  assign BUSY = busy_q;

  // ----------------------------------------------------------------
  // Checks, system domain
  // ----------------------------------------------------------------
  property p_start_seen;
    @(posedge CLOCK) disable iff (RST)
    start_ev |=> !bus_idle_q && (start_tgl_q != $past(start_tgl_q));
  endproperty
  a_start_seen: assert property (p_start_seen) else $error("start not flagged");

  property p_stop_idle;
    @(posedge CLOCK) disable iff (RST)
    stop_ev |=> bus_idle_q && !SDA_OE;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not flagged");

  property p_busy_load;
    @(posedge CLOCK) disable iff (RST)
    launch |=> busy_q && (wcnt_q == CW'(WR_CYCLES - 1));
  endproperty
  a_busy_load: assert property (p_busy_load) else $error("write timer not loaded");

  property p_busy_end;
    @(posedge CLOCK) disable iff (RST)
    busy_q && (wcnt_q == '0) |=> !busy_q;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy overran timer");

  property p_prot_drop;
    @(posedge CLOCK) disable iff (RST)
    launch && wp_s2_q && ptr_q[7] |-> (wr_en == 16'h0000) ##1 busy_q;
  endproperty
  a_prot_drop: assert property (p_prot_drop) else $error("protected word written");

  property p_low_supply;
    @(posedge CLOCK) disable iff (RST)
    launch && low_s2_q |-> (wr_en == 16'h0000);
  endproperty
  a_low_supply: assert property (p_low_supply) else $error("write at low supply");

  // ----------------------------------------------------------------
  // Checks, link domain
  // ----------------------------------------------------------------
  sequence s_wr_ack;
    oe_q ##1 ((st_q == LK_ADDR) && !oe_q);
  endsequence

  property p_ctrl_ack;
    @(negedge SCL_CLK) disable iff (lrst2_q)
    byte_done && (st_q == LK_CTRL) && ctrl_ok && !cb.rnw |=> s_wr_ack;
  endproperty
  a_ctrl_ack: assert property (p_ctrl_ack) else $error("write control not acked");

  sequence s_no_ack;
    !oe_q ##1 (st_q == LK_IDLE);
  endsequence

  property p_busy_nack;
    @(negedge SCL_CLK) disable iff (lrst2_q)
    byte_done && (st_q == LK_CTRL) && busy2_q |=> s_no_ack;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("ack while busy");

  property p_cs_miss;
    @(negedge SCL_CLK) disable iff (lrst2_q)
    byte_done && (st_q == LK_CTRL) && (cb.cs != cs2_q) |=> !oe_q;
  endproperty
  a_cs_miss: assert property (p_cs_miss) else $error("ack on wrong select");

  property p_addr_load;
    @(negedge SCL_CLK) disable iff (lrst2_q)
    byte_done && (st_q == LK_ADDR) |=> oe_q && (ptr_q == $past(rx_byte));
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("address not loaded");

  property p_page_wrap;
    @(negedge SCL_CLK) disable iff (lrst2_q)
    byte_done && (st_q == LK_WDATA) |=>
      (ptr_q[7:4] == $past(ptr_q[7:4])) && (ptr_q[3:0] == $past(ptr_q[3:0]) + 4'h1);
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("page pointer wrong");

  property p_read_inc;
    @(negedge SCL_CLK) disable iff (lrst2_q)
    rd_done |=> (ptr_q == $past(ptr_q) + 8'h01) && !oe_q;
  endproperty
  a_read_inc: assert property (p_read_inc) else $error("read pointer wrong");

  property p_read_nack;
    @(negedge SCL_CLK) disable iff (lrst2_q)
    !new_frame && (st_q == LK_RDATA) && (cnt_q == `EEPSL_MACK_SLOT) && sda_p_q
      |=> (st_q == LK_IDLE) && !oe_q;
  endproperty
  a_read_nack: assert property (p_read_nack) else $error("data held after nack");

endmodule : eepsl_slave

// ---- bench/eepsl_i2c_master.sv ----
// Behavioural two-wire bus master that makes the serial clock for the slave
`timescale 1ns/1ps
module eepsl_i2c_master (
  // Bus lines, data pulled low while pull is high
  output logic scl,
  output logic pull,
  input wire logic sda
);
  // Bit period 64 ns; conditions are held long so the system clock side sees them
  localparam int QTR = 16;
  localparam int HOLD = 700;

  // Bus idle at time zero, clock parked high between frames
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end

  // ----------------------------------------------------------------
  // Bus conditions and bit slots
  // ----------------------------------------------------------------
  // Start, also used as a repeated start; the first wait covers the bus free time
  task automatic start();
    #QTR;
    pull = 1'b0;
    #QTR;
    scl = 1'b1;
    #HOLD;
    wait (sda === 1'b1 && scl === 1'b1);
    pull = 1'b1;
    #HOLD;
    scl = 1'b0;
  endtask : start

  // Two data-free pulses, started while reset is held; the link side only resets on clock edges
  task automatic wake();
    for (int i = 0; i < 2; i++) begin
      #QTR;
      scl = 1'b0;
      #(2 * QTR);
      scl = 1'b1;
      #QTR;
    end
  endtask : wake

  // Stop: data rises while the clock is high
  task automatic stop();
    #QTR;
    pull = 1'b1;
    #QTR;
    scl = 1'b1;
    #HOLD;
    pull = 1'b0;
  endtask : stop

  // One clock pulse; data set mid-low, line sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    #QTR;
    pull = ~b;
    #QTR;
    scl = 1'b1;
    #QTR;
    r = sda;
    #QTR;
    scl = 1'b0;
  endtask : bit_io

  // Byte out, MSB first, then a released ninth pulse for the answer
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : send

  // Byte in; low ninth bit asks for more, high ends the read
  task automatic recv(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~more, r);
  endtask : recv
endmodule : eepsl_i2c_master

// ---- bench/eepsl_slave_tb.sv ----
// Self-checking bench of the serial EEPROM two-wire slave
`timescale 1ns/1ps
`include "eepsl_defines.svh"
module eepsl_slave_tb;
  import eepsl_pkg::*;
  // Short write cycle keeps the run brief
  localparam int WR_CYC = 200;
  logic clock, rst, wp_i, low_i, busy, sda_o, sda_oe, scl, pull, sda;
  logic [2:0] cs;
  logic [31:0] seed;
  logic [7:0] mem [256];
  int mismatches, tests_run;

  // Open-drain data line with pull-up
  assign sda = (sda_oe ? sda_o : 1'b1) & ~pull;

  eepsl_slave #(.WR_CYCLES(WR_CYC)) u_dut (
    .CLOCK(clock), .RST(rst), .SCL_CLK(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE(sda_oe), .CHIP_SELECT_PINS(cs), .WP(wp_i), .LOW_SUPPLY(low_i), .BUSY(busy));

  eepsl_i2c_master u_mst (.scl(scl), .pull(pull), .sda(sda));

  // System clock, 25 ns period
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    if (mismatches == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  // Start plus control byte, checking whether the slave answers
  task automatic ctrl(input logic [3:0] code, input logic [2:0] sel, input logic rnw,
                      input logic exp);
    eepsl_ctrl_t c;
    logic ack;
    c = '{code: code, cs: sel, rnw: rnw};
    u_mst.start();
    u_mst.send(c, ack);
    chk(16'(ack), 16'(exp));
  endtask : ctrl

  // Page write; the model keeps what a commit may store, later bytes winning
  task automatic wr(input logic [7:0] a, input int n, input logic wp, input logic low);
    logic [7:0] d, slot;
    logic ack;
    int cnt;
    @(negedge clock);
    wp_i = wp;
    low_i = low;
    ctrl(`EEPSL_CTRL_CODE, cs, 1'b0, 1'b1);
    u_mst.send(a, ack);
    chk(16'(ack), 16'h1);
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      d = seed[7:0];
      slot = {a[7:4], a[3:0] + 4'(i)};
      u_mst.send(d, ack);
      chk(16'(ack), 16'h1);
      if (!low && !(wp && slot >= `EEPSL_PROT_BASE)) begin
        mem[slot] = d;
      end
    end
    u_mst.stop();
    cnt = 0;
    // Busy length is counted while a polling attempt must go unanswered
    fork
      begin
        for (int k = 0; k < 20 && busy !== 1'b1; k++) begin
          @(negedge clock);
        end
        while (busy === 1'b1 && cnt < WR_CYC + 10) begin
          @(negedge clock);
          cnt++;
        end
        chk(16'(cnt), 16'(WR_CYC));
      end
      begin
        ctrl(`EEPSL_CTRL_CODE, cs, 1'b0, 1'b0);
        u_mst.stop();
      end
    join
  endtask : wr

  // Random read: address set by a write header, then a repeated start for the read
  task automatic rd(input logic [7:0] a, input int n);
    logic [7:0] d, ptr;
    logic ack;
    ctrl(`EEPSL_CTRL_CODE, cs, 1'b0, 1'b1);
    u_mst.send(a, ack);
    chk(16'(ack), 16'h1);
    ctrl(`EEPSL_CTRL_CODE, cs, 1'b1, 1'b1);
    ptr = a;
    for (int i = 0; i < n; i++) begin
      u_mst.recv(i < n - 1, d);
      chk(16'(d), 16'(mem[ptr]));
      ptr = ptr + 8'h01;
    end
    // Look after the release has settled, not in the launching time step
    #1;
    chk(16'(sda_oe), 16'h0);
    u_mst.stop();
  endtask : rd

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mismatches = 0;
    tests_run = 0;
    rst = 1'b1;
    wp_i = 1'b0;
    low_i = 1'b0;
    seed = 32'h77FEB886;
    cs = seed[2:0];
    // Without serial clock edges the link would keep unknown state into the first frame
    fork
      u_mst.wake();
    join_none
    repeat (3) @(negedge clock);
    rst = 1'b0;
    repeat (2) @(negedge clock);
    chk(16'(busy), 16'h0);
    chk(16'(sda_oe), 16'h0);
    // Foreign control code, then a select differing from the straps
    ctrl(4'h5, cs, 1'b0, 1'b0);
    u_mst.stop();
    ctrl(`EEPSL_CTRL_CODE, ~cs, 1'b0, 1'b0);
    u_mst.stop();
    // Overlong page, full pages, protected and low-supply writes
    wr(8'h0E, 18, 1'b0, 1'b0);
    wr(8'hF0, 16, 1'b0, 1'b0);
    wr(8'h90, 16, 1'b0, 1'b0);
    wr(8'h93, 3, 1'b1, 1'b0);
    wr(8'h05, 2, 1'b1, 1'b0);
    wr(8'h08, 2, 1'b0, 1'b1);
    rd(8'hFE, 4);
    rd(8'h90, 16);
    rd(8'h00, 16);
    close_out();
  end

  // Whole run needs about 125 us; a hang is cut off well beyond that
  initial begin
    #500000;
    mismatches++;
    close_out();
  end
endmodule : eepsl_slave_tb
